// ### core/fdm_memory_ctrl.v
// Bus-side control of a 4K x 12 battery-backed memory module.
// Assumes bus pins are asynchronous to i_sys_clk; the bus tristate
// wire is resolved outside from o_mux_addr_data_oe.
`timescale 1ns/1ps
`include "fdm_memory_map.vh"

module fdm_memory_ctrl
(
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rst_n,
    // Shared bus lines
    input wire i_address_latch_strobe,
    input wire [0:`FDM_WORD_W-1] i_mux_addr_data_in,
    output reg [0:`FDM_WORD_W-1] o_mux_addr_data_out,
    output reg o_mux_addr_data_oe,
    input wire [0:`FDM_FIELD_W-1] i_extended_field_address,
    input wire i_memory_disable_line_n,
    input wire i_read_data_phase,
    input wire i_write_data_phase,
    input wire i_bus_reset_n,
    // Module switches and protect lines
    input wire [0:`FDM_FIELD_W-1] i_field_select_switches,
    input wire i_full_write_protect_n,
    input wire i_upper_write_protect_n,
    input wire i_reset_hold_switch,
    // Row strobes and status
    output reg [`FDM_ROWS-1:0] o_ram_row_strobe_n,
    output reg o_standby,
    output reg o_module_selected,
    output reg o_write_blocked
);

    // Synchroniser stages
    reg [`FDM_SYNC_W-1:0] sync1_reg;
    reg [`FDM_SYNC_W-1:0] sync2_reg;
    wire [`FDM_SYNC_W-1:0] pin_vec;

    // Synchronised pin views
    wire als_s;
    wire [0:`FDM_WORD_W-1] mad_s;
    wire [0:`FDM_FIELD_W-1] field_s;
    wire memory_disable_line_n_s;
    wire fwp_n_s;
    wire uwp_n_s;
    wire [0:`FDM_FIELD_W-1] sw_s;
    wire hold_s;
    wire brst_n_s;
    wire wr_s;
    wire rd_s;

    // Edge detection
    reg als_d_reg;
    reg wr_d_reg;
    wire als_fall;
    wire als_rise;
    wire wr_rise;

    // Address latch and decode
    reg [1:0] upper_addr_reg;
    reg [`FDM_ROW_ADDR_W-1:0] low_addr_reg;
    reg [`FDM_ROWS-1:0] row_decode;

    // Standby and selection
    reg standby_reg;
    reg standby_next;
    wire reset_active;
    wire selected;

    // Row strobe timing
    reg [`FDM_HOLD_CNT_W-1:0] high_cnt_reg;
    reg [`FDM_HOLD_CNT_W-1:0] high_cnt_next;
    reg [`FDM_ROWS-1:0] strobe_next;
    wire high_time_met;
    wire any_row_low;

    // Write and read path
    wire write_protected;
    reg write_pulse_reg;
    reg [`FDM_WORD_W-1:0] write_data_reg;
    wire [`FDM_WORD_W-1:0] read_data;
    reg [0:`FDM_WORD_W-1] out_next;
    reg oe_next;

    // Pins into one vector, two flip-flops before use
    assign pin_vec = {i_read_data_phase,
                      i_write_data_phase,
                      i_bus_reset_n,
                      i_reset_hold_switch,
                      i_field_select_switches,
                      i_upper_write_protect_n,
                      i_full_write_protect_n,
                      i_memory_disable_line_n,
                      i_extended_field_address,
                      i_mux_addr_data_in,
                      i_address_latch_strobe};

    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1_reg <= `FDM_SYNC_IDLE;
            sync2_reg <= `FDM_SYNC_IDLE;
        end
        else
        begin
            sync1_reg <= pin_vec;
            sync2_reg <= sync1_reg;
        end
    end

    assign als_s = sync2_reg[`FDM_S_ALS];
    assign mad_s = sync2_reg[`FDM_S_MAD_HI:`FDM_S_MAD_LO];
    assign field_s = sync2_reg[`FDM_S_FIELD_HI:`FDM_S_FIELD_LO];
    assign memory_disable_line_n_s = sync2_reg[`FDM_S_MEMORY_DISABLE_LINE_N];
    assign fwp_n_s = sync2_reg[`FDM_S_FWP_N];
    assign uwp_n_s = sync2_reg[`FDM_S_UWP_N];
    assign sw_s = sync2_reg[`FDM_S_SW_HI:`FDM_S_SW_LO];
    assign hold_s = sync2_reg[`FDM_S_HOLD];
    assign brst_n_s = sync2_reg[`FDM_S_BRST_N];
    assign wr_s = sync2_reg[`FDM_S_WR];
    assign rd_s = sync2_reg[`FDM_S_RD];

    // Edge detectors look only at the second stage
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            als_d_reg <= 1'b1;
            wr_d_reg <= 1'b0;
        end
        else
        begin
            als_d_reg <= als_s;
            wr_d_reg <= wr_s;
        end
    end

    assign als_fall = als_d_reg & ~als_s;
    assign als_rise = ~als_d_reg & als_s;
    assign wr_rise = ~wr_d_reg & wr_s;

    // Upper two bits and low ten bits both latched on the strobe fall
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            upper_addr_reg <= `FDM_ROW_ZERO;
            low_addr_reg <= {`FDM_ROW_ADDR_W{1'b0}};
        end
        else if (als_fall)
        begin
            upper_addr_reg <= mad_s[`FDM_UPPER_MSB:`FDM_UPPER_LSB];
            low_addr_reg <= mad_s[`FDM_LOW_MSB:`FDM_LOW_LSB];
        end
    end

    // One-of-four active-low row decode
    always @*
    begin
        row_decode = `FDM_STROBE_IDLE;
        case (upper_addr_reg)
            2'h0: row_decode = 4'he;
            2'h1: row_decode = 4'hd;
            2'h2: row_decode = 4'hb;
            2'h3: row_decode = 4'h7;
            default: row_decode = `FDM_STROBE_IDLE;
        endcase
    end

    // Reset hold switch pulls the module reset low
    assign reset_active = ~brst_n_s | hold_s;

    // Field match against inverted switches, disable line high
    assign selected = memory_disable_line_n_s & (field_s == ~sw_s);

    // Standby set by reset, cleared by the first strobe rise after release
    always @*
    begin
        standby_next = standby_reg;
        if (reset_active)
        begin
            standby_next = 1'b1;
        end
        else if (standby_reg & als_rise)
        begin
            standby_next = 1'b0;
        end
    end

    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            standby_reg <= 1'b1;
        end
        else
        begin
            standby_reg <= standby_next;
        end
    end

    // Minimum high time before any row strobe may fall again
    assign any_row_low = ~(&o_ram_row_strobe_n);
    assign high_time_met = (high_cnt_reg >= `FDM_ROW_STROBE_MIN_HIGH_CYC);

    always @*
    begin
        high_cnt_next = high_cnt_reg;
        if (any_row_low)
        begin
            high_cnt_next = {`FDM_HOLD_CNT_W{1'b0}};
        end
        else if (!high_time_met)
        begin
            high_cnt_next = high_cnt_reg + 1'b1;
        end
    end

    // Row strobe next state
    always @*
    begin
        strobe_next = `FDM_STROBE_IDLE;
        if (standby_reg | reset_active)
        begin
            strobe_next = `FDM_STROBE_IDLE;
        end
        else if (als_s)
        begin
            strobe_next = `FDM_STROBE_IDLE;
        end
        else if (!selected)
        begin
            strobe_next = `FDM_STROBE_IDLE;
        end
        else if (any_row_low)
        begin
            strobe_next = o_ram_row_strobe_n;
        end
        else if (high_time_met & ~als_fall)
        begin
            strobe_next = row_decode;
        end
    end

    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_ram_row_strobe_n <= `FDM_STROBE_IDLE;
            high_cnt_reg <= {`FDM_HOLD_CNT_W{1'b0}};
        end
        else
        begin
            o_ram_row_strobe_n <= strobe_next;
            high_cnt_reg <= high_cnt_next;
        end
    end

    // Write protect: full blocks all, upper blocks rows above the first
    assign write_protected = ~fwp_n_s
                           | (~uwp_n_s & (upper_addr_reg != `FDM_ROW_ZERO));

    // One write per data phase, only with a row enabled
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            write_pulse_reg <= 1'b0;
            write_data_reg <= `FDM_WORD_ZERO;
            o_write_blocked <= 1'b0;
        end
        else
        begin
            write_pulse_reg <= wr_rise & any_row_low & selected
                             & ~standby_reg & ~write_protected;
            write_data_reg <= mad_s;
            if (wr_rise & any_row_low)
            begin
                o_write_blocked <= write_protected;
            end
        end
    end

    fdm_row_array u_row_array
    (
        .i_sys_clk(i_sys_clk),
        .i_ram_row_strobe_n(o_ram_row_strobe_n),
        .i_low_address_bits(low_addr_reg),
        .i_write_pulse(write_pulse_reg),
        .i_write_data(write_data_reg),
        .o_read_data(read_data)
    );

    // Read data onto the shared lines only in a selected read phase
    always @*
    begin
        out_next = `FDM_WORD_ZERO;
        oe_next = 1'b0;
        if (rd_s & ~wr_s & selected & any_row_low & ~standby_reg)
        begin
            out_next = read_data;
            oe_next = 1'b1;
        end
    end

    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_mux_addr_data_out <= `FDM_WORD_ZERO;
            o_mux_addr_data_oe <= 1'b0;
            o_standby <= 1'b1;
            o_module_selected <= 1'b0;
        end
        else
        begin
            o_mux_addr_data_out <= out_next;
            o_mux_addr_data_oe <= oe_next;
            o_standby <= standby_reg;
            o_module_selected <= selected;
        end
    end

endmodule // fdm_memory_ctrl

// ### core/fdm_memory_map.vh
// Constants for the field decoded memory controller.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef FDM_MEMORY_MAP_VH
`define FDM_MEMORY_MAP_VH

// Clock and timing
`define FDM_CLK_PERIOD_NS 10
`define FDM_ROW_STROBE_MIN_HIGH_NS 235
`define FDM_ROW_STROBE_MIN_HIGH_CYC \
    ((`FDM_ROW_STROBE_MIN_HIGH_NS + `FDM_CLK_PERIOD_NS - 1) / `FDM_CLK_PERIOD_NS)
`define FDM_HOLD_CNT_W 5

// Widths and geometry
`define FDM_WORD_W 12
`define FDM_ROWS 4
`define FDM_ROW_ADDR_W 10
`define FDM_MEM_ADDR_W 12
`define FDM_FIELD_W 3

// Field positions on the shared lines, bit 0 most significant
`define FDM_UPPER_MSB 0
`define FDM_UPPER_LSB 1
`define FDM_LOW_MSB 2
`define FDM_LOW_LSB 11

// Synchroniser vector positions
`define FDM_SYNC_W 26
`define FDM_S_ALS 0
`define FDM_S_MAD_LO 1
`define FDM_S_MAD_HI 12
`define FDM_S_FIELD_LO 13
`define FDM_S_FIELD_HI 15
`define FDM_S_MEMORY_DISABLE_LINE_N 16
`define FDM_S_FWP_N 17
`define FDM_S_UWP_N 18
`define FDM_S_SW_LO 19
`define FDM_S_SW_HI 21
`define FDM_S_HOLD 22
`define FDM_S_BRST_N 23
`define FDM_S_WR 24
`define FDM_S_RD 25

// Reset values
`define FDM_STROBE_IDLE 4'hf
`define FDM_WORD_ZERO 12'h000
`define FDM_ROW_ZERO 2'h0
`define FDM_SYNC_ZERO 26'h000_0000
`define FDM_SYNC_IDLE 26'h080_0001

`endif

// ### core/fdm_row_array.v
// Four rows of 1K x 12 storage, each row strobe acting as chip select.
// Assumes strobes and address come from registers on the same clock.
`timescale 1ns/1ps
`include "fdm_memory_map.vh"

module fdm_row_array
(
    // Clock
    input wire i_sys_clk,
    // Row access
    input wire [`FDM_ROWS-1:0] i_ram_row_strobe_n,
    input wire [`FDM_ROW_ADDR_W-1:0] i_low_address_bits,
    input wire i_write_pulse,
    input wire [`FDM_WORD_W-1:0] i_write_data,
    output wire [`FDM_WORD_W-1:0] o_read_data
);

    reg [`FDM_WORD_W-1:0] mem [0:(1 << `FDM_MEM_ADDR_W)-1];
    reg [`FDM_ROWS-1:0] strobe_prev_reg;
    reg [`FDM_ROW_ADDR_W-1:0] row_addr_reg [0:`FDM_ROWS-1];
    reg [1:0] active_row_reg;
    wire [`FDM_ROWS-1:0] strobe_fall;

    always @(posedge i_sys_clk)
    begin
        strobe_prev_reg <= i_ram_row_strobe_n;
    end

    genvar r;
    generate
        for (r = 0; r < `FDM_ROWS; r = r + 1)
        begin : g_row
            assign strobe_fall[r] = strobe_prev_reg[r] & ~i_ram_row_strobe_n[r];
            // Low address taken only on the strobe's falling edge
            always @(posedge i_sys_clk)
            begin
                if (strobe_fall[r])
                begin
                    row_addr_reg[r] <= i_low_address_bits;
                end
            end
        end
    endgenerate

    always @(posedge i_sys_clk)
    begin
        if (strobe_fall[1] | strobe_fall[3])
        begin
            active_row_reg[0] <= 1'b1;
        end
        else if (strobe_fall[0] | strobe_fall[2])
        begin
            active_row_reg[0] <= 1'b0;
        end
        if (strobe_fall[2] | strobe_fall[3])
        begin
            active_row_reg[1] <= 1'b1;
        end
        else if (strobe_fall[0] | strobe_fall[1])
        begin
            active_row_reg[1] <= 1'b0;
        end
        if (i_write_pulse & ~i_ram_row_strobe_n[active_row_reg])
        begin
            mem[{active_row_reg, row_addr_reg[active_row_reg]}] <= i_write_data;
        end
    end

    assign o_read_data = mem[{active_row_reg, row_addr_reg[active_row_reg]}];

endmodule // fdm_row_array

// ### bench/fdm_ctrl_monitor.sv
// Port assertions for the memory controller.
// Assumes bind into fdm_memory_ctrl; single clock domain.
`timescale 1ns/1ps
module fdm_ctrl_monitor
(
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rst_n,
    // Watched ports
    input wire i_address_latch_strobe,
    input wire i_memory_disable_line_n,
    input wire i_bus_reset_n,
    input wire i_reset_hold_switch,
    input wire [0:11] o_mux_addr_data_out,
    input wire o_mux_addr_data_oe,
    input wire [3:0] o_ram_row_strobe_n,
    input wire o_standby
);
    reg [4:0] hi_cnt_reg;
    // Cycles with all row strobes high
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            hi_cnt_reg <= 5'h1f;
        else if (o_ram_row_strobe_n != 4'hf)
            hi_cnt_reg <= 5'h00;
        else if (hi_cnt_reg != 5'h1f)
            hi_cnt_reg <= hi_cnt_reg + 5'h01;
    end
    default clocking dcb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    chk_one_row_low: assert property (o_ram_row_strobe_n == 4'hf || $onehot(~o_ram_row_strobe_n))
        else $error("more than one row strobe low");
    chk_als_high_idle: assert property (i_address_latch_strobe [*5] |-> o_ram_row_strobe_n == 4'hf)
        else $error("row strobe low while address strobe high");
    chk_disable_blocks: assert property (!i_memory_disable_line_n [*6] |->
        o_ram_row_strobe_n == 4'hf && !o_mux_addr_data_oe)
        else $error("access while memory disabled");
    chk_bus_reset_stby: assert property (!i_bus_reset_n [*5] |-> o_standby)
        else $error("bus reset did not set standby");
    chk_hold_sw_stby: assert property (i_reset_hold_switch [*5] |-> o_standby)
        else $error("hold switch did not set standby");
    chk_standby_quiet: assert property (o_standby |-> o_ram_row_strobe_n == 4'hf)
        else $error("row strobe low in standby");
    chk_stby_exit_cause: assert property ($fell(o_standby) |->
        i_bus_reset_n && !i_reset_hold_switch && o_ram_row_strobe_n == 4'hf)
        else $error("standby left without cause");
    chk_drive_row_low: assert property (o_mux_addr_data_oe |-> $past(o_ram_row_strobe_n) != 4'hf)
        else $error("bus driven with no row selected");
    chk_release_zero: assert property (!o_mux_addr_data_oe |-> o_mux_addr_data_out == 12'h000)
        else $error("read data present while released");
    chk_min_high_time: assert property (o_ram_row_strobe_n != 4'hf && $past(o_ram_row_strobe_n) == 4'hf
        |-> hi_cnt_reg >= 5'h18)
        else $error("row strobe high pulse too short");
endmodule // fdm_ctrl_monitor

bind fdm_memory_ctrl fdm_ctrl_monitor fdm_ctrl_monitor_i (.i_sys_clk, .i_rst_n,
    .i_address_latch_strobe, .i_memory_disable_line_n, .i_bus_reset_n, .i_reset_hold_switch,
    .o_mux_addr_data_out, .o_mux_addr_data_oe, .o_ram_row_strobe_n, .o_standby);

// ### bench/fdm_bus_master.sv
// Bus master model: multiplexed address then data on shared lines.
// Assumes tasks are called just after a falling clock edge.
`timescale 1ns/1ps
module fdm_bus_master
(
    // Clock
    input wire i_sys_clk,
    // Bus pins toward the module
    output reg o_als,
    output reg [0:11] o_lines,
    output reg o_rd,
    output reg o_wr
);
    initial
    begin
        o_als = 1'b1;
        o_lines = 12'h000;
        o_rd = 1'b0;
        o_wr = 1'b0;
    end
    // One cycle; read leaves garbage on the lines it does not own
    task cycle(input [11:0] addr, input wr_en, input [11:0] wdata);
    begin
        o_lines = addr;
        repeat (30) @(negedge i_sys_clk);
        o_als = 1'b0;
        repeat (5) @(negedge i_sys_clk);
        o_lines = wr_en ? wdata : ~addr;
        o_wr = wr_en;
        o_rd = !wr_en;
        repeat (8) @(negedge i_sys_clk);
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_lines = ~o_lines;
        repeat (6) @(negedge i_sys_clk);
        o_als = 1'b1;
    end
    endtask
endmodule // fdm_bus_master

// ### bench/tb_fdm_memory_ctrl.sv
// Self-checking bench for the memory controller.
// Assumes the bus master model drives the shared lines.
`timescale 1ns/1ps
module tb_fdm_memory_ctrl;
    reg i_sys_clk = 1'b0;
    reg i_rst_n = 1'b0;
    reg [0:2] extended_field_address = 3'h5;
    reg [0:2] sw = 3'h2;
    reg memory_disable_line_n = 1'b1;
    reg bus_reset_n = 1'b1;
    reg fwp_n = 1'b1;
    reg uwp_n = 1'b1;
    reg hold = 1'b0;
    reg prev_oe = 1'b0;
    reg [31:0] lfsr = 32'h0000_8511;
    reg [11:0] a;
    reg [11:0] shadow [0:4095];
    reg [15:0] exp_q [$];
    integer err_total = 0;
    integer samples_checked = 0;
    integer k;
    wire als, rd, wr, oe, standby, sel, blocked;
    wire [0:11] lines, mad_out;
    wire [3:0] strobe_n;
    wire [0:11] mad_in = oe ? mad_out : lines;
    always #5 i_sys_clk = ~i_sys_clk;
    fdm_bus_master fdm_bus_master_i (.i_sys_clk(i_sys_clk), .o_als(als), .o_lines(lines),
        .o_rd(rd), .o_wr(wr));
    fdm_memory_ctrl fdm_memory_ctrl_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_address_latch_strobe(als), .i_mux_addr_data_in(mad_in),
        .o_mux_addr_data_out(mad_out), .o_mux_addr_data_oe(oe), .i_extended_field_address(extended_field_address),
        .i_memory_disable_line_n(memory_disable_line_n), .i_read_data_phase(rd), .i_write_data_phase(wr),
        .i_bus_reset_n(bus_reset_n), .i_field_select_switches(sw), .i_full_write_protect_n(fwp_n),
        .i_upper_write_protect_n(uwp_n), .i_reset_hold_switch(hold),
        .o_ram_row_strobe_n(strobe_n), .o_standby(standby), .o_module_selected(sel),
        .o_write_blocked(blocked));
    function [31:0] lfsr_next(input [31:0] v);
        lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk_data(input string name, input [11:0] exp, input [11:0] got);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    end
    endtask
    task chk_strobe(input string name, input [3:0] exp, input [3:0] got);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    end
    endtask
    task chk_flag(input string name, input exp, input got);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("unexpected %s: expected %b, seen %b", name, exp, got);
        end
    end
    endtask
    task wr_word(input [11:0] addr, input [11:0] data, input ok);
    begin
        fdm_bus_master_i.cycle(addr, 1'b1, data);
        if (ok)
            shadow[addr] = data;
    end
    endtask
    task rd_word(input [11:0] addr, input ok);
    begin
        if (ok)
            exp_q.push_back({~(4'h1 << addr[11:10]), shadow[addr]});
        fdm_bus_master_i.cycle(addr, 1'b0, 12'h000);
    end
    endtask
    task end_sim;
    begin
        if (exp_q.size() != 0)
            err_total = err_total + 1;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // Each read that drives the bus takes the oldest note
    always @(posedge i_sys_clk)
    begin
        prev_oe <= oe;
        if (oe === 1'b1 && prev_oe === 1'b0)
        begin
            if (exp_q.size() == 0)
                chk_flag("read drive", 1'b0, oe);
            else
            begin
                chk_data("read data", exp_q[0][11:0], mad_out);
                chk_strobe("row strobes", exp_q[0][15:12], strobe_n);
                void'(exp_q.pop_front());
            end
        end
    end
    // Tests take about 2300 cycles
    initial
    begin
        #500_000;
        err_total = err_total + 1;
        end_sim;
    end
    initial
    begin
        repeat (5) @(negedge i_sys_clk);
        chk_flag("standby", 1'b1, standby);
        i_rst_n = 1'b1;
        rd_word(12'h000, 1'b0);
        for (k = 0; k < 8; k = k + 1)
        begin
            lfsr = lfsr_next(lfsr);
            a = {k[1:0], lfsr[9:0]};
            wr_word(a, lfsr[27:16], 1'b1);
            rd_word(a, 1'b1);
        end
        $display("test rows done");
        for (k = 0; k < 8; k = k + 1)
        begin
            sw = k[2:0];
            extended_field_address = ~k[2:0];
            rd_word(a, 1'b1);
            chk_flag("module selected", 1'b1, sel);
        end
        extended_field_address = 3'h4;
        rd_word(a, 1'b0);
        chk_flag("module selected", 1'b0, sel);
        extended_field_address = 3'h0;
        $display("test field select done");
        memory_disable_line_n = 1'b0;
        wr_word(a, ~shadow[a], 1'b0);
        chk_flag("module selected", 1'b0, sel);
        rd_word(a, 1'b0);
        memory_disable_line_n = 1'b1;
        rd_word(a, 1'b1);
        $display("test disable done");
        for (k = 0; k < 4; k = k + 1)
        begin
            lfsr = lfsr_next(lfsr);
            a = {k[0] ? 2'h3 : 2'h0, lfsr[9:0]};
            wr_word(a, lfsr[27:16], 1'b1);
            fwp_n = k[1];
            uwp_n = !k[1];
            wr_word(a, ~lfsr[27:16], k == 2);
            chk_flag("write blocked", k != 2, blocked);
            rd_word(a, 1'b1);
            fwp_n = 1'b1;
            uwp_n = 1'b1;
        end
        $display("test protect done");
        for (k = 0; k < 3; k = k + 1)
        begin
            hold = (k == 0);
            bus_reset_n = (k != 1);
            i_rst_n = (k != 2);
            repeat (8) @(negedge i_sys_clk);
            chk_flag("standby", 1'b1, standby);
            chk_strobe("row strobes", 4'hf, strobe_n);
            hold = 1'b0;
            bus_reset_n = 1'b1;
            i_rst_n = 1'b1;
            rd_word(a, 1'b0);
            rd_word(a, 1'b1);
        end
        $display("test standby done");
        end_sim;
    end
endmodule // tb_fdm_memory_ctrl
